// ---- include/tecc_pkg.sv ----
`default_nettype none
package tecc_pkg;
    // ------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------
    localparam int COUNT_WIDTH = 40;
    localparam int BYTE_COUNT = 5;
    localparam int PRESCALE_WIDTH = 5;
    localparam int PIN_FUNC_WIDTH = 8;

    // Counter clock dividers on the two VCO clocks
    localparam logic [4:0] RESONATOR_DIV = 5'h08;
    localparam logic [4:0] LC_DIV = 5'h14;

    // Function code that makes the pin the capture trigger
    localparam logic [7:0] PIN_FUNC_CAPTURE = 8'h27;

    // Byte index of the captured count, low byte first
    localparam logic [2:0] BYTE_IDX_LSB = 3'h0;
    localparam logic [2:0] BYTE_IDX_MSB = 3'h4;

    // Setting encodings
    localparam logic VCO_SEL_RESONATOR = 1'b0;
    localparam logic VCO_SEL_LC = 1'b1;
    localparam logic TRIG_SEL_SPI = 1'b0;
    localparam logic TRIG_SEL_PIN = 1'b1;

    // Reset values
    localparam logic [39:0] COUNT_RESET = 40'h00_0000_0000;
    localparam logic [7:0] READ_DATA_RESET = 8'h00;

    // Configuration bits from the register space
    typedef struct packed {
        logic counterEnableBit;
        logic counterClearBit;
        logic counterVcoSelect;
        logic captureTriggerSelect;
    } tecc_cfg_type;

    // One byte read of the captured count
    typedef struct packed {
        logic strobe;
        logic [2:0] byteIdx;
    } tecc_read_type;
endpackage : tecc_pkg
`default_nettype wire

// ---- hw/tecc_elapsed_time_counter.sv ----
// Overview of operation
// - Accepted trigger copies the counter into the 40-bit captured count.
// - Counter advances on resonator VCO divided by eight or LC VCO by twenty.
// - VCO select 0 picks resonator PLL, 1 picks LC PLL.
// - Trigger select 1 uses the pin, 0 uses SPI select falling edge.
// - Enable bit 0 holds counter at zero; 1 lets it count.
// - Counter increments continuously and wraps from all ones to zero.
// - SPI select falling edge captures while enabled, selected and armed.
// - Select edges ignored after a transaction reading MSB, until LSB read.
// - One burst may capture then re-arm, if it reads the LSB after the MSB.
// - Pin with function code 0x27 triggers capture on its configured edge.
// - After a pin capture, further pin edges ignored until LSB read.
// - Polarity invert chooses rising or falling pin edges as triggers.
// - Captured count readable as five byte-wide registers.
// - VCO select also steers validation VCO; a change flags disturbance.
// - Clear bit at 0 leaves the counter in normal operation.
`default_nettype none
module tecc_elapsed_time_counter #(
    parameter logic [4:0] RESONATOR_DIVIDE = tecc_pkg::RESONATOR_DIV,
    parameter logic [4:0] LC_DIVIDE = tecc_pkg::LC_DIV
) (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // Configuration bits
    input wire tecc_pkg::tecc_cfg_type cfg,
    // VCO clock ticks, one cycle per VCO edge
    input wire logic resonatorVcoTick,
    input wire logic lcVcoTick,
    // Trigger pin and its configuration
    input wire logic pinIn,
    input wire logic [tecc_pkg::PIN_FUNC_WIDTH-1:0] pinFunctionSelect,
    input wire logic pinPolarityInvert,
    // SPI select and byte reads of the captured count
    input wire logic spiSelectPin_n,
    input wire tecc_pkg::tecc_read_type readReq,
    // Read answer
    output logic [7:0] readData,
    output logic readValid,
    // Captured count and status
    output logic [tecc_pkg::COUNT_WIDTH-1:0] capturedCount,
    output logic captureArmed,
    output logic capturePulse,
    // Reference validation VCO steering
    output logic validationVcoSelect,
    output logic validationDisturb
);
    import tecc_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [PRESCALE_WIDTH-1:0] prescale_r;
    logic [COUNT_WIDTH-1:0] count_r;
    logic [COUNT_WIDTH-1:0] captured_r;
    logic pinPrev_r;
    logic spiPrev_r;
    logic spiLocked_r;
    logic pinLocked_r;
    logic msbSeen_r;
    logic [7:0] readData_r;
    logic readValid_r;
    logic capturePulse_r;
    logic vcoSel_r;
    logic disturb_r;
    logic vcoTick;
    logic [PRESCALE_WIDTH-1:0] divLast;
    logic countTick;
    logic pinLevel;
    logic pinEdge;
    logic pinIsTrigger;
    logic spiFall;
    logic spiRise;
    logic spiCapture;
    logic pinCapture;
    logic doCapture;
    logic lsbRead;
    logic msbRead;

    // Byte select of the captured count
    function automatic logic [7:0] pickByte(
        input logic [COUNT_WIDTH-1:0] value,
        input logic [2:0] idx
    );
        logic [7:0] b;
        b = 8'h00;
        for (int i = 0; i < BYTE_COUNT; i++) begin
            if (idx == 3'(i)) begin
                b = value[8*i +: 8];
            end
        end
        return b;
    endfunction

    // Trigger source decode, shared by capture and arming
    function automatic logic pinSourced(input tecc_cfg_type c);
        return c.captureTriggerSelect == TRIG_SEL_PIN;
    endfunction

    // ------------------------------------------------------------
    // Counter clock
    // ------------------------------------------------------------
    // source select
    assign vcoTick = (cfg.counterVcoSelect == VCO_SEL_LC) ?
                     lcVcoTick : resonatorVcoTick;
    assign divLast = (cfg.counterVcoSelect == VCO_SEL_LC) ?
                     (LC_DIVIDE - 5'h01) : (RESONATOR_DIVIDE - 5'h01);
    // Tick that advances the counter, one per divided period
    assign countTick = vcoTick && (prescale_r >= divLast);

    // Prescaler on the chosen VCO
    // Keeps its phase across a source change, so one period may run short
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prescale_r <= '0;
        end else if (clkEn) begin
            if (!cfg.counterEnableBit) begin
                prescale_r <= '0;
            end else if (countTick) begin
                prescale_r <= '0;
            end else if (vcoTick) begin
                prescale_r <= prescale_r + 5'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Elapsed time counter
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_r <= COUNT_RESET;
        end else if (clkEn) begin
            if (!cfg.counterEnableBit) begin
                count_r <= COUNT_RESET;
            end else if (cfg.counterClearBit) begin
                count_r <= COUNT_RESET;
            end else if (countTick) begin
                count_r <= count_r + 40'h00_0000_0001;
            end
        end
    end

    // ------------------------------------------------------------
    // Trigger detection
    // ------------------------------------------------------------
    // polarity invert turns falling into rising
    assign pinLevel = pinIn ^ pinPolarityInvert;
    assign pinEdge = pinLevel && !pinPrev_r;
    // pin acts as trigger only with its function code
    assign pinIsTrigger = (pinFunctionSelect == PIN_FUNC_CAPTURE);
    // Select edges against the previous sample
    assign spiFall = spiPrev_r && !spiSelectPin_n;
    assign spiRise = !spiPrev_r && spiSelectPin_n;

    // Edge history of the pins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pinPrev_r <= 1'b0;
            spiPrev_r <= 1'b1;
        end else if (clkEn) begin
            pinPrev_r <= pinLevel;
            spiPrev_r <= spiSelectPin_n;
        end
    end

    // Byte reads that steer arming
    assign lsbRead = readReq.strobe && (readReq.byteIdx == BYTE_IDX_LSB);
    assign msbRead = readReq.strobe && (readReq.byteIdx == BYTE_IDX_MSB);

    // select falling edge captures while armed
    assign spiCapture = cfg.counterEnableBit &&
                        !pinSourced(cfg) &&
                        spiFall && !spiLocked_r;
    assign pinCapture = cfg.counterEnableBit &&
                        pinSourced(cfg) &&
                        pinIsTrigger && pinEdge && !pinLocked_r;
    assign doCapture = spiCapture || pinCapture;

    // ------------------------------------------------------------
    // Capture and arming
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            captured_r <= COUNT_RESET;
        end else if (clkEn) begin
            // all 40 bits taken in one edge
            if (doCapture) begin
                captured_r <= count_r;
            end
        end
    end

    // MSB read seen within the current transaction
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            msbSeen_r <= 1'b0;
        end else if (clkEn) begin
            // a later LSB read in the same burst re-arms
            if (msbRead) begin
                msbSeen_r <= 1'b1;
            end else if (lsbRead || spiRise) begin
                msbSeen_r <= 1'b0;
            end
        end
    end

    // SPI lockout, set at transaction end, cleared by LSB read
    // Deciding at select rise keeps an MSB-then-LSB burst armed
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            spiLocked_r <= 1'b0;
        end else if (clkEn) begin
            // lock after transaction that read the MSB
            if (spiRise && (msbSeen_r || msbRead) && !lsbRead) begin
                spiLocked_r <= 1'b1;
            end else if (lsbRead) begin
                spiLocked_r <= 1'b0;
            end
        end
    end

    // Pin lockout, set by capture, cleared by LSB read
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pinLocked_r <= 1'b0;
        end else if (clkEn) begin
            if (pinCapture) begin
                pinLocked_r <= 1'b1;
            end else if (lsbRead) begin
                pinLocked_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Byte read path
    // ------------------------------------------------------------
    // Reads see the count held before a same-edge capture
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            readData_r <= READ_DATA_RESET;
            readValid_r <= 1'b0;
        end else if (clkEn) begin
            readValid_r <= readReq.strobe;
            if (readReq.strobe) begin
                readData_r <= pickByte(captured_r, readReq.byteIdx);
            end
        end
    end

    // ------------------------------------------------------------
    // Capture event pulse
    // ------------------------------------------------------------
    // One cycle, the cycle after the capturing edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            capturePulse_r <= 1'b0;
        end else if (clkEn) begin
            capturePulse_r <= doCapture;
        end
    end

    // ------------------------------------------------------------
    // Validation VCO steering
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            vcoSel_r <= VCO_SEL_RESONATOR;
            disturb_r <= 1'b0;
        end else if (clkEn) begin
            // shared select, change flagged one cycle
            vcoSel_r <= cfg.counterVcoSelect;
            disturb_r <= (vcoSel_r != cfg.counterVcoSelect);
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Registered values straight out
    assign readData = readData_r;
    assign readValid = readValid_r;
    assign capturedCount = captured_r;
    assign capturePulse = capturePulse_r;
    // Armed reflects the lock of the source now selected
    assign captureArmed = pinSourced(cfg) ? !pinLocked_r : !spiLocked_r;
    assign validationVcoSelect = vcoSel_r;
    assign validationDisturb = disturb_r;
endmodule : tecc_elapsed_time_counter
`default_nettype wire

// ---- test/tecc_props.sv ----
`default_nettype none
module tecc_props (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Inputs watched
    input wire tecc_pkg::tecc_cfg_type cfg,
    input wire logic spiSelectPin_n,
    input wire tecc_pkg::tecc_read_type readReq,
    // Outputs watched
    input wire logic [7:0] readData,
    input wire logic readValid,
    input wire logic [tecc_pkg::COUNT_WIDTH-1:0] capturedCount,
    input wire logic captureArmed,
    input wire logic capturePulse,
    input wire logic validationVcoSelect,
    input wire logic validationDisturb
);
    timeunit 1ns;
    timeprecision 1ps;
    import tecc_pkg::*;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic [7:0] expByte;
    // Byte a read of this index should return
    always_ff @(posedge clk) begin
        expByte <= 8'(capturedCount >> {readReq.byteIdx, 3'h0});
    end
    // Reads, captures, locks and steering
    property p_rdValid;
        readReq.strobe |=> readValid;
    endproperty
    a_rdValid: assert property (p_rdValid)
        else $error("read not answered");
    property p_rdByte;
        readReq.strobe && readReq.byteIdx <= BYTE_IDX_MSB |=>
            readData == expByte;
    endproperty
    a_rdByte: assert property (p_rdByte)
        else $error("read byte wrong");
    property p_rdZero;
        readReq.strobe && readReq.byteIdx > BYTE_IDX_MSB |=> readData == 8'h00;
    endproperty
    a_rdZero: assert property (p_rdZero)
        else $error("unused index not zero");
    property p_spiCap;
        cfg.counterEnableBit && cfg.captureTriggerSelect == TRIG_SEL_SPI &&
        captureArmed && $fell(spiSelectPin_n) |-> ##[1:2] capturePulse;
    endproperty
    a_spiCap: assert property (p_spiCap)
        else $error("select fall not captured");
    property p_locked;
        !captureArmed |=> $stable(capturedCount);
    endproperty
    a_locked: assert property (p_locked)
        else $error("capture while locked");
    property p_pulse;
        $changed(capturedCount) |-> capturePulse;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("count changed without pulse");
    property p_enOff;
        !cfg.counterEnableBit |=> !capturePulse;
    endproperty
    a_enOff: assert property (p_enOff)
        else $error("capture while disabled");
    property p_vco;
        1'b1 |=> validationVcoSelect == $past(cfg.counterVcoSelect);
    endproperty
    a_vco: assert property (p_vco)
        else $error("validation vco not steered");
    property p_disturb;
        validationDisturb == $changed(validationVcoSelect);
    endproperty
    a_disturb: assert property (p_disturb)
        else $error("validation change not flagged");
    // Main scenarios reached
    c_spiCap: cover property (capturePulse && !cfg.captureTriggerSelect);
    c_pinCap: cover property (capturePulse && cfg.captureTriggerSelect);
    c_lock: cover property ($fell(captureArmed));
    c_disturb: cover property (validationDisturb);
endmodule // tecc_props
bind tecc_elapsed_time_counter tecc_props tecc_props_i (.clk, .rst_n, .cfg,
    .spiSelectPin_n, .readReq, .readData, .readValid, .capturedCount,
    .captureArmed, .capturePulse, .validationVcoSelect, .validationDisturb);
`default_nettype wire

// ---- test/tecc_host_model.sv ----
`default_nettype none
module tecc_host_model (
    // Clock and read answer
    input wire logic clk,
    input wire logic [7:0] readData,
    // Select, read request and trigger pin
    output logic spiSelectPin_n,
    output var tecc_pkg::tecc_read_type readReq,
    output logic pinIn
);
    timeunit 1ns;
    timeprecision 1ps;
    import tecc_pkg::*;
    // Idle: deselected, no strobe, pin low
    initial begin
        spiSelectPin_n = 1'b1;
        readReq = '0;
        pinIn = 1'b0;
    end
    // Select or pin level, changed after an edge
    task automatic drive(input logic isPin, input logic v);
        @(posedge clk) #1;
        if (isPin) begin
            pinIn = v;
        end else begin
            spiSelectPin_n = v;
        end
    endtask
    // byte read, index released as inverse
    task automatic rdByte(input logic [2:0] idx, output logic [7:0] d);
        @(posedge clk) #1;
        readReq = '{1'b1, idx};
        @(posedge clk) #1;
        readReq = '{1'b0, ~idx};
        d = readData;
    endtask
endmodule // tecc_host_model
`default_nettype wire

// ---- test/tecc_elapsed_time_counter_tb.sv ----
`default_nettype none
module tecc_elapsed_time_counter_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tecc_pkg::*;
    // ------------------------------------------------------------
    // Stimulus, answers and counters
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    tecc_cfg_type cfg = '0;
    logic resTick = 1'b0;
    logic lcTick = 1'b0;
    logic [7:0] pinFunc = 8'h00;
    logic pinInv = 1'b0;
    logic spiSel_n, pinIn, readValid, armed, pulse, vcoSel;
    tecc_read_type readReq;
    logic [7:0] readData, rd;
    logic [39:0] count;
    int mismatches = 0;
    int cmp_count = 0;
    // Free-running clock
    always #5 clk = ~clk;
    tecc_elapsed_time_counter tecc_elapsed_time_counter_i (.clk, .rst_n,
        .clkEn(1'b1), .cfg, .resonatorVcoTick(resTick), .lcVcoTick(lcTick),
        .pinIn, .pinFunctionSelect(pinFunc), .pinPolarityInvert(pinInv),
        .spiSelectPin_n(spiSel_n), .readReq, .readData, .readValid,
        .capturedCount(count), .captureArmed(armed), .capturePulse(pulse),
        .validationVcoSelect(vcoSel), .validationDisturb());
    tecc_host_model tecc_host_model_i (.clk, .readData,
        .spiSelectPin_n(spiSel_n), .readReq, .pinIn);
    task automatic chk(input string n, input logic [39:0] e,
        input logic [39:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic ticks(input int n, input logic lc);
        repeat (n) begin
            @(posedge clk) #1;
            resTick = 1'b1;
            lcTick = lc;
        end
        @(posedge clk) #1;
        resTick = 1'b0;
        lcTick = 1'b0;
    endtask
    task automatic start(input logic vco);
        @(posedge clk) #1;
        cfg = '{1'b0, 1'b0, vco, cfg.captureTriggerSelect};
        repeat (2) @(posedge clk);
        #1 cfg.counterEnableBit = 1'b1;
    endtask
    task automatic trig(input logic isPin, input logic v);
        tecc_host_model_i.drive(isPin, v);
        @(posedge clk) #1;
        if (!isPin) tecc_host_model_i.drive(1'b0, 1'b1);
    endtask
    task automatic t_spiRead();
        start(VCO_SEL_RESONATOR);
        chk("validation res", 40'h0, 40'(vcoSel));
        ticks(24, 1'b0);
        trig(1'b0, 1'b0);
        chk("count", 40'h3, count);
        tecc_host_model_i.drive(1'b0, 1'b0);
        for (int i = 5; i >= 0; i--) begin
            tecc_host_model_i.rdByte(3'(i), rd);
            chk("byte", (i == 0) ? 40'h3 : 40'h0, 40'(rd));
        end
        tecc_host_model_i.drive(1'b0, 1'b1);
        @(posedge clk) #1 chk("burst armed", 40'h1, 40'(armed));
    endtask
    task automatic t_spiLock();
        ticks(8, 1'b0);
        tecc_host_model_i.drive(1'b0, 1'b0);
        tecc_host_model_i.rdByte(BYTE_IDX_MSB, rd);
        tecc_host_model_i.drive(1'b0, 1'b1);
        @(posedge clk) #1 chk("locked", 40'h0, 40'(armed));
        ticks(8, 1'b0);
        trig(1'b0, 1'b0);
        chk("held", 40'h4, count);
        tecc_host_model_i.rdByte(BYTE_IDX_LSB, rd);
        trig(1'b0, 1'b0);
        chk("rearmed", 40'h5, count);
    endtask
    task automatic t_pin();
        cfg.captureTriggerSelect = TRIG_SEL_PIN;
        pinFunc = PIN_FUNC_CAPTURE;
        start(VCO_SEL_RESONATOR);
        ticks(16, 1'b0);
        trig(1'b0, 1'b0);
        chk("select ignored", 40'h5, count);
        trig(1'b1, 1'b1);
        chk("pin rise", 40'h2, count);
        ticks(8, 1'b0);
        trig(1'b1, 1'b0);
        trig(1'b1, 1'b1);
        chk("pin locked", 40'h2, count);
        tecc_host_model_i.rdByte(BYTE_IDX_LSB, rd);
        pinInv = 1'b1;
        trig(1'b1, 1'b0);
        chk("pin fall", 40'h3, count);
        tecc_host_model_i.rdByte(BYTE_IDX_LSB, rd);
        pinFunc = 8'h26;
        trig(1'b1, 1'b1);
        trig(1'b1, 1'b0);
        chk("pin function", 40'h3, count);
    endtask
    task automatic t_enable();
        cfg.captureTriggerSelect = TRIG_SEL_SPI;
        cfg.counterClearBit = 1'b1;
        ticks(16, 1'b0);
        trig(1'b0, 1'b0);
        chk("clear", 40'h0, count);
        start(VCO_SEL_RESONATOR);
        ticks(8, 1'b0);
        trig(1'b0, 1'b0);
        chk("normal", 40'h1, count);
        cfg.counterEnableBit = 1'b0;
        ticks(8, 1'b0);
        trig(1'b0, 1'b0);
        chk("disabled", 40'h1, count);
        cfg.counterEnableBit = 1'b1;
        trig(1'b0, 1'b0);
        chk("zeroed", 40'h0, count);
        start(VCO_SEL_LC);
        chk("validation lc", 40'h1, 40'(vcoSel));
        ticks(40, 1'b1);
        trig(1'b0, 1'b0);
        chk("lc count", 40'h2, count);
    endtask
    task automatic finish_test();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Reset, then the scenarios
    initial begin
        repeat (10) @(posedge clk);
        #1 rst_n = 1'b1;
        chk("armed after reset", 40'h1, 40'(armed));
        t_spiRead();
        t_spiLock();
        t_pin();
        t_enable();
        finish_test();
    end
    // Watchdog
    initial begin
        #20us;
        mismatches++;
        finish_test();
    end
endmodule // tecc_elapsed_time_counter_tb
`default_nettype wire
